// [pkg/evp_defs.svh]
// Timing counts, page geometry and codes for the engine video page interface
`ifndef EVP_DEFS_SVH
`define EVP_DEFS_SVH
`define EVP_CLK_MHZ 250
`define EVP_WAIT_US 1000
`define EVP_WAIT_CYC (`EVP_WAIT_US * `EVP_CLK_MHZ)
`define EVP_INIT_ROT_US 100
`define EVP_INIT_ROT_CYC (`EVP_INIT_ROT_US * `EVP_CLK_MHZ)
`define EVP_LAST_ROT_US 100
`define EVP_LAST_ROT_CYC (`EVP_LAST_ROT_US * `EVP_CLK_MHZ)
`define EVP_VSYNC_MAX_NS 400
`define EVP_VSYNC_MAX_CYC (`EVP_VSYNC_MAX_NS / 4)
`define EVP_LINE_PIX 16
`define EVP_PAGE_LINES 8
`define EVP_MONO_PLANES 1
`define EVP_COLOR_PLANES 4
`define EVP_SIZE_A4 3'h3
`define EVP_SIZE_B5 3'b101
`define EVP_SIZE_LTR 3'h1
`define EVP_SIZE_LGL 3'h4
`define EVP_SIZE_NONE 3'b000
`define EVP_SYNC_IDLE 16'hFF81
`endif

// [pkg/evp_pkg.sv]
// Types shared by the engine video page interface
package evp_pkg;
    typedef enum logic [2:0] {
        EVP_CAS_NONE = 3'h0,
        EVP_CAS_A4 = 3'h1,
        EVP_CAS_B5 = 3'h2,
        EVP_CAS_LTR = 3'h3,
        EVP_CAS_LGL = 3'h4,
        EVP_CAS_BAD = 3'h5
    } evp_cassette_type;
    typedef struct packed {
        logic print_seq_cmd;
        logic feeder_supply_fail;
    } evp_mech_type;
    typedef struct packed {
        logic feeder_motor_on;
        logic feeder_motor_fast;
        logic feed_solenoid;
        logic feeder_remote;
        logic feeder_fail_report;
    } evp_feeder_type;
endpackage

// [logic/evp_fifo.sv]
// Small flip-flop FIFO between pixel capture and the modulator output
`timescale 1ns/100ps
module evp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data = mem_ff[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (clk_en && push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || (clk_en && flush)) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr_ff <= bump(wr_ptr_ff);
            end
            if (pop) begin
                rd_ptr_ff <= bump(rd_ptr_ff);
            end
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// [logic/evp_engine.sv]
// Engine controller: readiness, page handshake, pixel path, power and feeder
`timescale 1ns/100ps
`include "evp_defs.svh"
// ----------------------------------------
// How it works
// - Wait state after power-up, no ready
// - Wait ends, drive engine_ready_n low
// - Request starts print command and initial_rotation
// - Vsync pulse follows initial_rotation end
// - Pixel bus becomes 8-bit modulator_data
// - Sample next page request during page
// - No request: last rotation then standby
// - Request pending: continue without last rotation
// - Power saving entered and left on command
// - Safe state plus flag drops supply_hold
// - Decode size switches to cassette size
// - Fast motor plus solenoid, normal at roller
// - Remote output follows printer commands
// - Missing 24 V reported to mechanics
// - Relayed feeder failure shown as comms failure
// ----------------------------------------
module evp_engine #(
    parameter int WAIT_CYC = `EVP_WAIT_CYC,
    parameter int INIT_ROT_CYC = `EVP_INIT_ROT_CYC,
    parameter int LAST_ROT_CYC = `EVP_LAST_ROT_CYC,
    parameter int VSYNC_MAX_CYC = `EVP_VSYNC_MAX_CYC,
    parameter int LINE_PIX = `EVP_LINE_PIX,
    parameter int PAGE_LINES = `EVP_PAGE_LINES,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Video controller link
    input wire logic page_request_n,
    input wire logic [7:0] pixel_bus_n,
    input wire logic color_mode,
    input wire logic power_save_req,
    output logic engine_ready_n,
    output logic page_vsync_n,
    output logic line_sync_n,
    output logic comm_fail,
    output logic power_saving,
    // Laser modulator
    output logic [7:0] modulator_data,
    output logic modulator_valid,
    input wire logic modulator_ready,
    // Mechanical controller
    output evp_pkg::evp_mech_type mech_out,
    input wire logic mech_feeder_fail,
    // Power supply
    input wire logic switch_off_flag,
    output logic supply_hold,
    // Paper feeder
    input wire logic size_switch_1,
    input wire logic size_switch_2,
    input wire logic size_switch_3,
    input wire logic sheet_at_roller2,
    input wire logic feeder_power_cmd,
    input wire logic feeder_24v_ok,
    output evp_pkg::evp_cassette_type cassette_ff,
    output evp_pkg::evp_feeder_type feeder_ff
);
    import evp_pkg::*;

    typedef enum logic [6:0] {
        ST_WAIT = 7'h01,
        ST_READY = 7'h02,
        ST_INIT_ROT = 7'h04,
        ST_VSYNC = 7'h08,
        ST_PAGE = 7'h10,
        ST_LAST_ROT = 7'h20,
        ST_SAVE = 7'h40
    } evp_state_type;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    localparam int NS = 16;
    logic [NS-1:0] pin_raw;
    logic [NS-1:0] sync1_ff;
    logic [NS-1:0] sync2_ff;
    assign pin_raw = {page_request_n, pixel_bus_n, power_save_req, switch_off_flag,
                      size_switch_1, size_switch_2, size_switch_3, sheet_at_roller2,
                      feeder_24v_ok};
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync1_ff <= `EVP_SYNC_IDLE;
            sync2_ff <= `EVP_SYNC_IDLE;
        end else if (clk_en) begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
        end
    end
    logic req_s;
    logic [7:0] pix_s;
    logic save_s;
    logic off_s;
    logic [2:0] csw_s;
    logic roller_s;
    logic v24_s;
    assign req_s = !sync2_ff[15];
    assign pix_s = ~sync2_ff[14:7];
    assign save_s = sync2_ff[6];
    assign off_s = sync2_ff[5];
    assign csw_s = sync2_ff[4:2];
    assign roller_s = sync2_ff[1];
    assign v24_s = sync2_ff[0];

    function automatic evp_cassette_type decode_size(input logic [2:0] sw);
        unique case (sw)
            `EVP_SIZE_A4: decode_size = EVP_CAS_A4;
            `EVP_SIZE_B5: decode_size = EVP_CAS_B5;
            `EVP_SIZE_LTR: decode_size = EVP_CAS_LTR;
            `EVP_SIZE_LGL: decode_size = EVP_CAS_LGL;
            `EVP_SIZE_NONE: decode_size = EVP_CAS_NONE;
            default: decode_size = EVP_CAS_BAD;
        endcase
    endfunction

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    evp_state_type state_ff;
    logic [31:0] timer_ff;
    logic [15:0] pix_cnt_ff;
    logic [15:0] line_cnt_ff;
    logic [2:0] plane_ff;
    logic next_req_ff;
    logic color_ff;
    logic page_start;
    logic plane_done;
    logic line_end;
    logic pix_take;
    logic fifo_in_ready;
    assign line_end = (pix_cnt_ff == 16'(LINE_PIX - 1));
    assign pix_take = (state_ff == ST_PAGE) && fifo_in_ready;
    assign plane_done = pix_take && line_end && (line_cnt_ff == 16'(PAGE_LINES - 1));
    assign page_start = plane_done &&
        (plane_ff == 3'(color_ff ? `EVP_COLOR_PLANES - 1 : `EVP_MONO_PLANES - 1));

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_ff <= ST_WAIT;
            timer_ff <= '0;
        end else if (clk_en) begin
            unique case (state_ff)
                ST_WAIT: begin
                    timer_ff <= timer_ff + 1'b1;
                    if (timer_ff == 32'(WAIT_CYC - 1)) begin
                        state_ff <= ST_READY;
                        timer_ff <= '0;
                    end
                end
                ST_READY: begin
                    if (save_s) begin
                        state_ff <= ST_SAVE;
                    end else if (req_s) begin
                        state_ff <= ST_INIT_ROT;
                        timer_ff <= '0;
                    end
                end
                ST_INIT_ROT: begin
                    timer_ff <= timer_ff + 1'b1;
                    if (timer_ff == 32'(INIT_ROT_CYC - 1)) begin
                        state_ff <= ST_VSYNC;
                        timer_ff <= '0;
                    end
                end
                ST_VSYNC: begin
                    timer_ff <= timer_ff + 1'b1;
                    if (timer_ff == 32'(VSYNC_MAX_CYC - 1)) begin
                        state_ff <= ST_PAGE;
                    end
                end
                ST_PAGE: begin
                    if (plane_done && !page_start) begin
                        state_ff <= ST_VSYNC;
                        timer_ff <= '0;
                    end else if (page_start && (next_req_ff || req_s)) begin
                        timer_ff <= '0;
                        state_ff <= ST_VSYNC;
                    end else if (page_start) begin
                        timer_ff <= '0;
                        state_ff <= ST_LAST_ROT;
                    end
                end
                ST_LAST_ROT: begin
                    timer_ff <= timer_ff + 1'b1;
                    if (timer_ff == 32'(LAST_ROT_CYC - 1)) begin
                        state_ff <= ST_READY;
                    end
                end
                ST_SAVE: begin
                    if (!save_s) begin
                        state_ff <= ST_READY;
                    end
                end
            endcase
        end
    end

    // Plane, line and pixel counters
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pix_cnt_ff <= '0;
            line_cnt_ff <= '0;
            plane_ff <= '0;
            color_ff <= 1'b0;
        end else if (clk_en) begin
            if (state_ff == ST_INIT_ROT) begin
                color_ff <= color_mode;
                plane_ff <= '0;
            end
            if (pix_take) begin
                pix_cnt_ff <= line_end ? '0 : pix_cnt_ff + 1'b1;
                if (line_end) begin
                    line_cnt_ff <= plane_done ? '0 : line_cnt_ff + 1'b1;
                end
                if (plane_done) begin
                    plane_ff <= page_start ? '0 : plane_ff + 1'b1;
                end
            end
        end
    end

    // Next-page request sampling
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            next_req_ff <= 1'b0;
        end else if (clk_en) begin
            if (page_start) begin
                next_req_ff <= 1'b0;
            end else if (state_ff == ST_PAGE && req_s) begin
                next_req_ff <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Video link outputs
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            engine_ready_n <= 1'b1;
            page_vsync_n <= 1'b1;
            line_sync_n <= 1'b1;
            power_saving <= 1'b0;
            comm_fail <= 1'b0;
            mech_out <= '0;
        end else if (clk_en) begin
            engine_ready_n <= (state_ff == ST_WAIT) || (state_ff == ST_SAVE);
            page_vsync_n <= !(state_ff == ST_VSYNC && timer_ff == '0);
            line_sync_n <= !(pix_take && pix_cnt_ff == '0);
            power_saving <= (state_ff == ST_SAVE);
            comm_fail <= mech_feeder_fail;
            mech_out.print_seq_cmd <= (state_ff == ST_INIT_ROT);
            mech_out.feeder_supply_fail <= feeder_ff.feeder_fail_report;
        end
    end

    // ----------------------------------------
    // Pixel path
    // ----------------------------------------
    logic f_valid;
    logic [7:0] f_data;
    evp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .flush(state_ff == ST_SAVE),
        .in_valid(state_ff == ST_PAGE),
        .in_ready(fifo_in_ready),
        .in_data(pix_s),
        .out_valid(f_valid),
        .out_ready(modulator_ready || !modulator_valid),
        .out_data(f_data)
    );
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            modulator_data <= '0;
            modulator_valid <= 1'b0;
        end else if (clk_en && (modulator_ready || !modulator_valid)) begin
            modulator_data <= f_data;
            modulator_valid <= f_valid;
        end
    end

    // ----------------------------------------
    // Power-off handshake
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            supply_hold <= 1'b1;
        end else if (clk_en) begin
            if (off_s && (state_ff == ST_READY || state_ff == ST_SAVE ||
                          state_ff == ST_WAIT)) begin
                supply_hold <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Paper feeder
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cassette_ff <= EVP_CAS_NONE;
            feeder_ff <= '0;
        end else if (clk_en) begin
            cassette_ff <= decode_size(csw_s);
            feeder_ff.feeder_remote <= feeder_power_cmd;
            feeder_ff.feeder_fail_report <= feeder_power_cmd && !v24_s;
            if (state_ff == ST_INIT_ROT && timer_ff == '0) begin
                feeder_ff.feeder_motor_on <= 1'b1;
                feeder_ff.feeder_motor_fast <= 1'b1;
                feeder_ff.feed_solenoid <= 1'b1;
            end else if (roller_s && feeder_ff.feeder_motor_fast) begin
                feeder_ff.feeder_motor_fast <= 1'b0;
                feeder_ff.feed_solenoid <= 1'b0;
            end else if (state_ff == ST_READY) begin
                feeder_ff.feeder_motor_on <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_wait_not_ready;
        @(posedge sys_clk) disable iff (!rst_n)
        state_ff == ST_WAIT |=> engine_ready_n;
    endproperty
    a_wait_not_ready: assert property (p_wait_not_ready) else $error("ready in wait");
    property p_ready_low;
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && state_ff == ST_READY |=> !engine_ready_n;
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("ready not driven");
    property p_req_start;
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && state_ff == ST_READY && req_s && !save_s |=> state_ff == ST_INIT_ROT;
    endproperty
    a_req_start: assert property (p_req_start) else $error("request ignored");
    property p_vsync_pulse;
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && $rose(state_ff == ST_VSYNC) |=> !page_vsync_n;
    endproperty
    a_vsync_pulse: assert property (p_vsync_pulse) else $error("no vsync");
    property p_mod_data;
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && f_valid && !modulator_valid |=> modulator_data == $past(f_data);
    endproperty
    a_mod_data: assert property (p_mod_data) else $error("modulator data wrong");
    property p_last_rot;
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && page_start && !next_req_ff && !req_s |=> state_ff == ST_LAST_ROT;
    endproperty
    a_last_rot: assert property (p_last_rot) else $error("no last rotation");
    property p_continue;
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && page_start && next_req_ff |=> state_ff == ST_VSYNC;
    endproperty
    a_continue: assert property (p_continue) else $error("run not continued");
    property p_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        !supply_hold |=> !supply_hold;
    endproperty
    a_hold: assert property (p_hold) else $error("supply hold returned");
    property p_fail_relay;
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && mech_feeder_fail |=> comm_fail;
    endproperty
    a_fail_relay: assert property (p_fail_relay) else $error("fail not relayed");
    c_page: cover property (@(posedge sys_clk) page_start);
    c_save: cover property (@(posedge sys_clk) state_ff == ST_SAVE);
    c_off: cover property (@(posedge sys_clk) !supply_hold);
endmodule

// [test/evp_video_model.sv]
// Behavioural video controller that requests pages and sends pixel planes
`timescale 1ns/100ps
module evp_video_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Job control
    input wire logic load,
    input wire logic [3:0] job_pages,
    input wire logic color_mode,
    // Engine side
    input wire logic engine_ready_n,
    input wire logic page_vsync_n,
    output logic page_request_n,
    output logic [7:0] pixel_bus_n
);
    logic [3:0] pending_ff;
    logic [1:0] plane_ff;

    // ----------------------------------------
    // Page request
    // ----------------------------------------
    assign page_request_n = !((pending_ff != 4'h0) && (engine_ready_n == 1'b0));
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pending_ff <= 4'h0;
        end else if (load) begin
            pending_ff <= job_pages;
        end else if (!page_vsync_n && plane_ff == 2'h0 && pending_ff != 4'h0) begin
            pending_ff <= pending_ff - 4'h1;
        end
    end

    // ----------------------------------------
    // Plane data, changed on each vertical sync
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n || load) begin
            plane_ff <= 2'h0;
            pixel_bus_n <= 8'hFF;
        end else if (!page_vsync_n) begin
            plane_ff <= color_mode ? plane_ff + 2'h1 : 2'h0;
            case ({color_mode, plane_ff})
                3'h4: pixel_bus_n <= ~8'h1E;
                3'h5: pixel_bus_n <= ~8'h2D;
                3'h6: pixel_bus_n <= ~8'h3C;
                3'h7: pixel_bus_n <= ~8'h4B;
                default: pixel_bus_n <= ~8'h5A;
            endcase
        end
    end
endmodule

// [test/evp_engine_bench.sv]
// Self-checking bench for the engine controller
`timescale 1ns/100ps
module evp_engine_bench;
    import evp_pkg::*;
    localparam int WAIT_CYC = 20;
    localparam int INIT_ROT_CYC = 20;
    localparam int LAST_ROT_CYC = 20;
    localparam int VSYNC_MAX_CYC = 4;
    localparam int PIX = 8;
    localparam logic [7:0] CVAL [4] = '{8'h1E, 8'h2D, 8'h3C, 8'h4B};
    localparam logic [5:0] ROW_IN [8] = '{6'h1E, 6'h2C, 6'h09, 6'h27,
                                          6'h02, 6'h3D, 6'h10, 6'h36};
    localparam evp_cassette_type ROW_CAS [8] = '{EVP_CAS_A4, EVP_CAS_B5, EVP_CAS_LTR,
        EVP_CAS_LGL, EVP_CAS_NONE, EVP_CAS_BAD, EVP_CAS_BAD, EVP_CAS_BAD};
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic page_request_n;
    logic [7:0] pixel_bus_n;
    logic color_mode = 1'b0;
    logic power_save_req = 1'b0;
    logic modulator_ready = 1'b1;
    logic mech_feeder_fail = 1'b0;
    logic switch_off_flag = 1'b0;
    logic size_switch_1 = 1'b0;
    logic size_switch_2 = 1'b0;
    logic size_switch_3 = 1'b0;
    logic sheet_at_roller2 = 1'b0;
    logic feeder_power_cmd = 1'b0;
    logic feeder_24v_ok = 1'b1;
    logic clk_en = 1'b1;
    logic engine_ready_n, page_vsync_n, line_sync_n, comm_fail, power_saving;
    logic [7:0] modulator_data;
    logic modulator_valid, supply_hold;
    evp_mech_type mech_out;
    evp_cassette_type cassette_ff;
    evp_feeder_type feeder_ff;
    logic load = 1'b0;
    logic [3:0] job_pages = 4'h0;
    logic stall = 1'b0;
    logic [3:0] cyc = 4'h0;
    logic held = 1'b0;
    logic [7:0] last_data = 8'h00;
    logic [7:0] exp_byte = 8'h00;
    int j_xfer = 0, j_vs = 0, j_ls = 0, gap = 0, first_gap = 0, max_gap = 0;
    int fails = 0;
    int n_tests = 0;

    evp_engine #(.WAIT_CYC(WAIT_CYC), .INIT_ROT_CYC(INIT_ROT_CYC), .LAST_ROT_CYC(LAST_ROT_CYC),
        .VSYNC_MAX_CYC(VSYNC_MAX_CYC), .LINE_PIX(4), .PAGE_LINES(2), .FIFO_DEPTH(8)) u_evp_engine (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .page_request_n(page_request_n),
        .pixel_bus_n(pixel_bus_n), .color_mode(color_mode), .power_save_req(power_save_req),
        .engine_ready_n(engine_ready_n), .page_vsync_n(page_vsync_n), .line_sync_n(line_sync_n),
        .comm_fail(comm_fail), .power_saving(power_saving), .modulator_data(modulator_data),
        .modulator_valid(modulator_valid), .modulator_ready(modulator_ready),
        .mech_out(mech_out), .mech_feeder_fail(mech_feeder_fail),
        .switch_off_flag(switch_off_flag), .supply_hold(supply_hold),
        .size_switch_1(size_switch_1), .size_switch_2(size_switch_2),
        .size_switch_3(size_switch_3), .sheet_at_roller2(sheet_at_roller2),
        .feeder_power_cmd(feeder_power_cmd), .feeder_24v_ok(feeder_24v_ok),
        .cassette_ff(cassette_ff), .feeder_ff(feeder_ff));

    evp_video_model u_evp_video_model (.sys_clk(sys_clk), .rst_n(rst_n), .load(load),
        .job_pages(job_pages), .color_mode(color_mode), .engine_ready_n(engine_ready_n),
        .page_vsync_n(page_vsync_n), .page_request_n(page_request_n), .pixel_bus_n(pixel_bus_n));

    // ----------------------------------------
    // Clock, modulator stall and monitor
    // ----------------------------------------
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 4'h1;
        modulator_ready <= !(stall && cyc[3:2] != 2'b00);
    end
    always @(posedge sys_clk) begin
        if (load === 1'b1) begin
            j_xfer = 0;
            j_vs = 0;
            j_ls = 0;
            max_gap = 0;
        end
        gap = gap + 1;
        if (held === 1'b1) check_byte(modulator_data, last_data);
        held = (modulator_valid === 1'b1) && (modulator_ready !== 1'b1);
        last_data = modulator_data;
        if (modulator_valid === 1'b1 && modulator_ready === 1'b1) begin
            exp_byte = color_mode ? CVAL[(j_xfer / PIX) % 4] : 8'h5A;
            check_byte(modulator_data, exp_byte);
            j_xfer = j_xfer + 1;
            gap = 0;
        end
        if (page_vsync_n === 1'b0) begin
            if (j_vs == 0) first_gap = gap;
            else if (gap > max_gap) max_gap = gap;
            j_vs = j_vs + 1;
            gap = 0;
        end
        if (line_sync_n === 1'b0) j_ls = j_ls + 1;
    end

    // ----------------------------------------
    // Compare, wait and job tasks
    // ----------------------------------------
    task automatic check_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t bit got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t data got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_cas(input evp_cassette_type got, input evp_cassette_type exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t cassette got %0d exp %0d", $time, got, exp);
        end
    endtask
    task automatic check_range(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            fails++;
            $display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    function automatic logic sig(input int w);
        case (w)
            0: return power_saving;
            1: return engine_ready_n;
            2: return mech_out.print_seq_cmd;
            3: return supply_hold;
            default: return page_vsync_n;
        endcase
    endfunction
    task automatic wait_for(input int w, input logic v, input int bound, output int n);
        for (n = 1; n <= bound; n++) begin
            @(posedge sys_clk);
            if (sig(w) === v) break;
        end
        n_tests++;
        if (n > bound) begin
            fails++;
            $display("ERROR %0t wait %0d timed out", $time, w);
            finish_test();
        end
    endtask
    task automatic start_job(input int p, input logic c);
        color_mode <= c;
        job_pages <= p[3:0];
        load <= 1'b1;
        @(posedge sys_clk);
        load <= 1'b0;
    endtask
    task automatic end_job(input int p, input int planes);
        int k;
        for (k = 0; k < 3000 && j_xfer < p * planes * PIX; k++) @(posedge sys_clk);
        check_range(j_xfer, p * planes * PIX, p * planes * PIX);
        check_range(j_vs, p * planes, p * planes);
        check_range(j_ls, p * planes * 2, p * planes * 2);
    endtask
    task automatic finish_test();
        if (fails == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int n;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        check_bit(engine_ready_n, 1'b1);
        check_bit(supply_hold, 1'b1);
        check_bit(page_vsync_n, 1'b1);
        wait_for(1, 1'b0, WAIT_CYC + 10, n);
        check_range(n, WAIT_CYC - 1, WAIT_CYC + 6);
        for (int i = 0; i < 8; i++) begin
            {size_switch_1, size_switch_2, size_switch_3, feeder_power_cmd, feeder_24v_ok,
                mech_feeder_fail} <= ROW_IN[i];
            repeat (6) @(posedge sys_clk);
            check_cas(cassette_ff, ROW_CAS[i]);
            check_bit(feeder_ff.feeder_remote, ROW_IN[i][2]);
            check_bit(feeder_ff.feeder_fail_report, ROW_IN[i][2] & ~ROW_IN[i][1]);
            check_bit(mech_out.feeder_supply_fail, ROW_IN[i][2] & ~ROW_IN[i][1]);
            check_bit(comm_fail, ROW_IN[i][0]);
        end
        {size_switch_1, size_switch_2, size_switch_3} <= 3'b011;
        {feeder_power_cmd, feeder_24v_ok, mech_feeder_fail} <= 3'b110;
        // Mono page with modulator stalls
        stall <= 1'b1;
        start_job(1, 1'b0);
        wait_for(2, 1'b1, 20, n);
        check_bit(feeder_ff.feeder_motor_fast, 1'b1);
        check_bit(feeder_ff.feed_solenoid, 1'b1);
        wait_for(4, 1'b0, INIT_ROT_CYC + 20, n);
        check_range(n, INIT_ROT_CYC - 3, INIT_ROT_CYC + VSYNC_MAX_CYC);
        sheet_at_roller2 <= 1'b1;
        repeat (5) @(posedge sys_clk);
        check_bit(feeder_ff.feeder_motor_fast, 1'b0);
        check_bit(feeder_ff.feeder_motor_on, 1'b1);
        sheet_at_roller2 <= 1'b0;
        end_job(1, 1);
        stall <= 1'b0;
        // Two colour pages back to back
        start_job(2, 1'b1);
        end_job(2, 4);
        check_range(max_gap, 0, LAST_ROT_CYC - 1);
        // Power saving on and off
        power_save_req <= 1'b1;
        wait_for(0, 1'b1, LAST_ROT_CYC + 30, n);
        clk_en <= 1'b0;
        power_save_req <= 1'b0;
        repeat (8) @(posedge sys_clk);
        check_bit(power_saving, 1'b1);
        clk_en <= 1'b1;
        wait_for(0, 1'b0, 10, n);
        // Last page with power-off during print
        start_job(1, 1'b0);
        wait_for(2, 1'b1, 20, n);
        switch_off_flag <= 1'b1;
        end_job(1, 1);
        check_range(first_gap, LAST_ROT_CYC + INIT_ROT_CYC, 100000);
        check_bit(supply_hold, 1'b1);
        wait_for(3, 1'b0, LAST_ROT_CYC + 20, n);
        check_range(n, LAST_ROT_CYC - 2, LAST_ROT_CYC + 20);
        finish_test();
    end
endmodule
